/* File: pkg/supervisor_pkg.sv */
// constants, pin indices and state encodings for the supervisor
// assumes a single 40 MHz system clock and no software-visible registers
`default_nettype none
package supervisor_pkg;

    // =========================================================
    // clock and times
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int HOLD_TIME_MS = 250;
    localparam int WDOG_TIME_MS = 1000;
    localparam int DEBOUNCE_TIME_MS = 10;
    // least times: kHz times ms is exact here, so no rounding is lost
    localparam int HOLD_CYC_DEF = (HOLD_TIME_MS * CLK_KHZ + 0);
    localparam int WDOG_CYC_DEF = WDOG_TIME_MS * CLK_KHZ;
    localparam int DEBOUNCE_CYC_DEF = DEBOUNCE_TIME_MS * CLK_KHZ;
    localparam int CNT_W_DEF = 26;

    // =========================================================
    // serial command byte
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_CNT_W = 3;
    localparam int DIR_BIT = 7;
    localparam logic DIR_WRITE = 1'b1;

    // =========================================================
    // synchronised pins
    localparam int NPINS = 9;
    localparam int PIN_SUPPLY = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_CS = 2;
    localparam int PIN_SDI = 3;
    localparam int PIN_RAM_EN = 4;
    localparam int PIN_UPPER = 5;
    localparam int PIN_LOWER = 6;
    localparam int PIN_KICK = 7;
    localparam int PIN_RST = 8;
    localparam logic [NPINS-1:0] PIN_RST_VAL = 9'h1F0;

    // =========================================================
    // reset causes
    localparam logic [1:0] CAUSE_POWER = 2'h0;
    localparam logic [1:0] CAUSE_WDOG = 2'h1;
    localparam logic [1:0] CAUSE_BUTTON = 2'h2;

    // =========================================================
    // state machines
    typedef enum logic [1:0] {
        ST_FAIL = 2'h0,
        ST_POWERUP = 2'h1,
        ST_RUN = 2'h3,
        ST_PULSE = 2'h2
    } sup_state_type;

    typedef enum logic [1:0] {
        PH_CMD = 2'h0,
        PH_DATA_IN = 2'h1,
        PH_DATA_OUT = 2'h2,
        PH_DONE = 2'h3
    } phase_type;

endpackage
`default_nettype wire

/* File: pkg/serial_cmd_if.sv */
// link between the supervisor front end and the serial command decoder
// assumes both ends run on clk_sys; strobes are one cycle wide
`timescale 1ns/1ps
`default_nettype none
interface serial_cmd_if;
    logic frame_on;
    logic bit_rise;
    logic bit_fall;
    logic sdi;
    logic [supervisor_pkg::BYTE_W-1:0] rd_byte;
    logic cmd_valid;
    logic cmd_write;
    logic [supervisor_pkg::ADDR_W-1:0] cmd_addr;
    logic wr_valid;
    logic [supervisor_pkg::BYTE_W-1:0] wr_byte;
    logic sdo;
    logic sdo_en;

    modport link (
        output frame_on, bit_rise, bit_fall, sdi, rd_byte,
        input cmd_valid, cmd_write, cmd_addr, wr_valid, wr_byte, sdo, sdo_en
    );
    modport dec (
        input frame_on, bit_rise, bit_fall, sdi, rd_byte,
        output cmd_valid, cmd_write, cmd_addr, wr_valid, wr_byte, sdo, sdo_en
    );
endinterface
`default_nettype wire

/* File: core/serial_cmd_decoder.sv */
// serial command decoder: command byte, one data byte in or out, lsb first
// assumes bit strobes already synchronised and qualified by the front end
`timescale 1ns/1ps
`default_nettype none
module serial_cmd_decoder (
    input wire logic clk_sys,
    input wire logic rstn,
    serial_cmd_if.dec ifc
);
    import supervisor_pkg::*;

    // =========================================================
    // state
    phase_type phase_r;
    logic [BIT_CNT_W-1:0] cnt_r;
    logic [BYTE_W-1:0] shift_r;
    logic [BYTE_W-1:0] out_r;
    logic cmd_valid_r, cmd_write_r, wr_valid_r, sdo_r, sdo_en_r;
    logic [ADDR_W-1:0] cmd_addr_r;
    logic [BYTE_W-1:0] wr_byte_r;

    wire [BYTE_W-1:0] shift_nxt = {ifc.sdi, shift_r[BYTE_W-1:1]};
    wire [BIT_CNT_W-1:0] cnt_nxt = BIT_CNT_W'(cnt_r + 1'b1);
    wire byte_done = (cnt_r == BIT_CNT_W'(BYTE_W - 1));
    wire is_write = (shift_nxt[DIR_BIT] == DIR_WRITE);

    // =========================================================
    // sequencer
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            phase_r <= PH_CMD;
            cnt_r <= '0;
            shift_r <= '0;
            out_r <= '0;
            cmd_valid_r <= 1'b0;
            cmd_write_r <= 1'b0;
            cmd_addr_r <= '0;
            wr_valid_r <= 1'b0;
            wr_byte_r <= '0;
            sdo_r <= 1'b0;
            sdo_en_r <= 1'b0;
        end else begin
            cmd_valid_r <= 1'b0;
            wr_valid_r <= 1'b0;
            if (!ifc.frame_on) begin
                // partial transfers are dropped, next select starts clean
                phase_r <= PH_CMD; // [RQ18]
                cnt_r <= '0;
                sdo_en_r <= 1'b0;
            end else begin
                unique case (phase_r)
                    PH_CMD: if (ifc.bit_rise) begin
                        shift_r <= shift_nxt; // [RQ13]
                        cnt_r <= cnt_nxt;
                        if (byte_done) begin
                            cmd_valid_r <= 1'b1;
                            cmd_write_r <= is_write; // [RQ15]
                            cmd_addr_r <= shift_nxt[ADDR_W-1:0]; // [RQ14]
                            phase_r <= is_write ? PH_DATA_IN : PH_DATA_OUT; // [RQ15]
                        end
                    end
                    PH_DATA_IN: if (ifc.bit_rise) begin
                        shift_r <= shift_nxt;
                        cnt_r <= cnt_nxt;
                        if (byte_done) begin
                            wr_valid_r <= 1'b1;
                            wr_byte_r <= shift_nxt;
                            phase_r <= PH_DONE;
                        end
                    end
                    PH_DATA_OUT: if (ifc.bit_fall) begin
                        sdo_en_r <= 1'b1;
                        sdo_r <= (cnt_r == '0) ? ifc.rd_byte[0] : out_r[0];
                        out_r <= (cnt_r == '0) ? (ifc.rd_byte >> 1) : (out_r >> 1);
                        cnt_r <= cnt_nxt;
                        if (byte_done) begin
                            phase_r <= PH_DONE;
                        end
                    end
                    PH_DONE: if (ifc.bit_fall) begin
                        // extra clocks are ignored; line released after last bit
                        sdo_en_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign ifc.cmd_valid = cmd_valid_r;
    assign ifc.cmd_write = cmd_write_r;
    assign ifc.cmd_addr = cmd_addr_r;
    assign ifc.wr_valid = wr_valid_r;
    assign ifc.wr_byte = wr_byte_r;
    assign ifc.sdo = sdo_r;
    assign ifc.sdo_en = sdo_en_r;

    // =========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_abort_idle: assert property (!ifc.frame_on |=> phase_r == PH_CMD && cnt_r == '0 && !sdo_en_r) // [RQ18]
        else $error("partial transfer not abandoned");
    chk_cmd_direction: assert property (cmd_valid_r |-> cmd_write_r == (phase_r == PH_DATA_IN)) // [RQ15]
        else $error("direction bit misrouted");
    chk_cmd_address: assert property (cmd_valid_r |-> cmd_addr_r == shift_r[ADDR_W-1:0]) // [RQ14]
        else $error("address not low seven bits");
    chk_data_after_cmd: assert property ($rose(sdo_en_r) |-> $past(phase_r) == PH_DATA_OUT && !$past(cmd_valid_r)) // [RQ13]
        else $error("data driven before command byte");
    cov_write_byte: cover property (cmd_valid_r && cmd_write_r ##[1:400] wr_valid_r);
    cov_read_byte: cover property (cmd_valid_r && !cmd_write_r ##[1:400] $fell(sdo_en_r));

endmodule // serial_cmd_decoder
`default_nettype wire

/* File: core/portable_system_supervisor.sv */
// supervisor top: reset sequencing, watchdog, button, sram gating, serial front
// assumes a 40 MHz clk_sys; all pins arrive asynchronous to it
// Operation
// [RQ1] host holds chip select high during transfers
// [RQ2] host drives ram enable low for sram
// [RQ3] high byte select needs upper and enable
// [RQ4] low byte select needs lower and enable
// [RQ5] interrupt follows flag and enable together
// [RQ6] reset on fail, watchdog, powerup, button
// [RQ7] debounced external reset gives long pulse
// [RQ8] missing watchdog kick forces reset
// [RQ9] supply below threshold asserts reset immediately
// [RQ10] serial ignored while supply is low
// [RQ11] inputs disabled until powerup hold ends; sram select inputs are gated by supply only, not by the hold
// [RQ12] reset held for hold time after return
// [RQ13] first byte of transfer is command
// [RQ14] command bits zero to six address
// [RQ15] command bit seven selects read/write
// [RQ16] sram selects inactive during power transients
// [RQ17] serial bits timed by host clock
// [RQ18] deselect abandons partial transfer
`timescale 1ns/1ps
`default_nettype none
module portable_system_supervisor #(
    parameter int HOLD_CYC = supervisor_pkg::HOLD_CYC_DEF,
    parameter int WDOG_CYC = supervisor_pkg::WDOG_CYC_DEF,
    parameter int DEBOUNCE_CYC = supervisor_pkg::DEBOUNCE_CYC_DEF,
    parameter int CNT_W = supervisor_pkg::CNT_W_DEF
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic supply_ok,
    input wire logic serial_clk,
    input wire logic serial_cs,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic ram_enable_in_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    output logic sram_high_byte_select_n,
    output logic sram_low_byte_select_n,
    input wire logic alarm_flag,
    input wire logic alarm_int_enable,
    output logic alarm_int,
    input wire logic watchdog_kick_n,
    input wire logic cpu_reset_in_n,
    output logic cpu_reset_out,
    output logic cpu_reset_oe,
    output logic [1:0] reset_cause,
    output logic access_ok,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [supervisor_pkg::ADDR_W-1:0] cmd_addr,
    output logic wr_valid,
    output logic [supervisor_pkg::BYTE_W-1:0] wr_data,
    input wire logic [supervisor_pkg::BYTE_W-1:0] rd_data
);
    import supervisor_pkg::*;

    // =========================================================
    // pin synchronisers
    // three stages per pin; a change counts once stages two and three agree
    logic [NPINS-1:0] pin_raw;
    logic [NPINS-1:0] sync1_r;
    logic [NPINS-1:0] sync2_r;
    logic [NPINS-1:0] sync3_r;
    logic [NPINS-1:0] pin_lvl_r;
    logic [NPINS-1:0] pin_lvl_nxt;

    assign pin_raw[PIN_SUPPLY] = supply_ok;
    assign pin_raw[PIN_SCLK] = serial_clk;
    assign pin_raw[PIN_CS] = serial_cs;
    assign pin_raw[PIN_SDI] = serial_data_in;
    assign pin_raw[PIN_RAM_EN] = ram_enable_in_n;
    assign pin_raw[PIN_UPPER] = upper_byte_sel_n;
    assign pin_raw[PIN_LOWER] = lower_byte_sel_n;
    assign pin_raw[PIN_KICK] = watchdog_kick_n;
    assign pin_raw[PIN_RST] = cpu_reset_in_n;

    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_filt
            assign pin_lvl_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync2_r[gi] : pin_lvl_r[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sync1_r <= PIN_RST_VAL;
            sync2_r <= PIN_RST_VAL;
            sync3_r <= PIN_RST_VAL;
            pin_lvl_r <= PIN_RST_VAL;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    wire supply_lvl = pin_lvl_r[PIN_SUPPLY];
    wire sclk_lvl = pin_lvl_r[PIN_SCLK];
    wire cs_lvl = pin_lvl_r[PIN_CS];
    wire ram_en_lvl_n = pin_lvl_r[PIN_RAM_EN];
    wire upper_lvl_n = pin_lvl_r[PIN_UPPER];
    wire lower_lvl_n = pin_lvl_r[PIN_LOWER];
    wire kick_lvl_n = pin_lvl_r[PIN_KICK];
    wire rst_pin_lvl_n = pin_lvl_r[PIN_RST];

    // =========================================================
    // serial clock edges
    logic sclk_prev_r;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_lvl;
        end
    end

    wire sclk_rise = sclk_lvl && !sclk_prev_r; // [RQ17]
    wire sclk_fall = !sclk_lvl && sclk_prev_r; // [RQ17]

    // =========================================================
    // reset sequencer
    sup_state_type state_r;
    sup_state_type state_nxt;
    logic [CNT_W-1:0] hold_cnt_r;
    logic [CNT_W-1:0] wdog_cnt_r;
    logic [CNT_W-1:0] deb_cnt_r;
    logic cpu_reset_oe_r;
    logic cpu_reset_out_r;
    logic access_ok_r;
    logic [1:0] cause_r;

    wire hold_done = (hold_cnt_r == CNT_W'(HOLD_CYC - 1));
    wire wdog_hit = (wdog_cnt_r == CNT_W'(WDOG_CYC - 1));
    // own drive reads back low on the pin, so only look while released
    wire button_low = !rst_pin_lvl_n && !cpu_reset_oe_r;
    wire deb_hit = button_low && (deb_cnt_r == CNT_W'(DEBOUNCE_CYC - 1));
    wire kick_seen = !kick_lvl_n;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_FAIL: if (supply_lvl) begin
                state_nxt = ST_POWERUP;
            end
            ST_POWERUP: if (!supply_lvl) begin
                state_nxt = ST_FAIL;
            end else if (hold_done) begin
                state_nxt = ST_RUN; // [RQ12]
            end
            ST_RUN: if (!supply_lvl) begin
                state_nxt = ST_FAIL; // [RQ9]
            end else if (wdog_hit || deb_hit) begin
                state_nxt = ST_PULSE; // [RQ8] [RQ7]
            end
            ST_PULSE: if (!supply_lvl) begin
                state_nxt = ST_FAIL;
            end else if (hold_done) begin
                state_nxt = ST_RUN; // [RQ7]
            end
        endcase
    end

    // hold counter runs only in the timed states and restarts on any move
    wire hold_run = (state_nxt == state_r) && (state_r == ST_POWERUP || state_r == ST_PULSE);
    wire [CNT_W-1:0] hold_cnt_nxt = hold_run ? CNT_W'(hold_cnt_r + 1'b1) : '0;
    wire [CNT_W-1:0] wdog_cnt_nxt = (state_r != ST_RUN || kick_seen) ? '0 : CNT_W'(wdog_cnt_r + 1'b1);
    wire [CNT_W-1:0] deb_cnt_nxt = (state_r != ST_RUN || !button_low) ? '0 : CNT_W'(deb_cnt_r + 1'b1);
    wire reset_nxt = (state_nxt != ST_RUN); // [RQ6]
    wire access_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_PULSE); // [RQ11] [RQ10]
    wire [1:0] cause_nxt = (state_nxt == ST_FAIL) ? CAUSE_POWER :
                           (state_r == ST_RUN && state_nxt == ST_PULSE) ? (wdog_hit ? CAUSE_WDOG : CAUSE_BUTTON) :
                           cause_r;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r <= ST_FAIL;
            hold_cnt_r <= '0;
            wdog_cnt_r <= '0;
            deb_cnt_r <= '0;
            cpu_reset_oe_r <= 1'b1;
            cpu_reset_out_r <= 1'b0;
            access_ok_r <= 1'b0;
            cause_r <= CAUSE_POWER;
        end else begin
            state_r <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            wdog_cnt_r <= wdog_cnt_nxt;
            deb_cnt_r <= deb_cnt_nxt;
            cpu_reset_oe_r <= reset_nxt;
            cpu_reset_out_r <= 1'b0;
            access_ok_r <= access_nxt;
            cause_r <= cause_nxt;
        end
    end

    // =========================================================
    // sram chip enables and interrupt
    logic high_sel_r;
    logic low_sel_r;
    logic alarm_int_r;

    wire ram_open = supply_lvl && !ram_en_lvl_n; // [RQ2] [RQ16]
    wire high_sel_nxt = !(ram_open && !upper_lvl_n); // [RQ3]
    wire low_sel_nxt = !(ram_open && !lower_lvl_n); // [RQ4]
    wire alarm_nxt = alarm_flag && alarm_int_enable; // [RQ5]

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            high_sel_r <= 1'b1;
            low_sel_r <= 1'b1;
            alarm_int_r <= 1'b0;
        end else begin
            high_sel_r <= high_sel_nxt;
            low_sel_r <= low_sel_nxt;
            alarm_int_r <= alarm_nxt;
        end
    end

    // =========================================================
    // serial front end
    serial_cmd_if ifc ();

    assign ifc.frame_on = cs_lvl && access_ok_r; // [RQ1] [RQ10] [RQ11]
    assign ifc.bit_rise = sclk_rise;
    assign ifc.bit_fall = sclk_fall;
    assign ifc.sdi = pin_lvl_r[PIN_SDI];
    assign ifc.rd_byte = rd_data;

    serial_cmd_decoder u_dec (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ifc(ifc)
    );

    // =========================================================
    // outputs
    assign serial_data_out = ifc.sdo;
    assign serial_data_oe = ifc.sdo_en;
    assign sram_high_byte_select_n = high_sel_r;
    assign sram_low_byte_select_n = low_sel_r;
    assign alarm_int = alarm_int_r;
    assign cpu_reset_out = cpu_reset_out_r;
    assign cpu_reset_oe = cpu_reset_oe_r;
    assign reset_cause = cause_r;
    assign access_ok = access_ok_r;
    assign cmd_valid = ifc.cmd_valid;
    assign cmd_write = ifc.cmd_write;
    assign cmd_addr = ifc.cmd_addr;
    assign wr_valid = ifc.wr_valid;
    assign wr_data = ifc.wr_byte;

    // =========================================================
    // checks
    logic [CNT_W-1:0] rst_len_r;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rst_len_r <= '0;
        end else if (!cpu_reset_oe_r) begin
            rst_len_r <= '0;
        end else if (rst_len_r != '1) begin
            rst_len_r <= CNT_W'(rst_len_r + 1'b1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_high_sel_gate: assert property (!high_sel_r |-> $past(!ram_en_lvl_n && !upper_lvl_n && supply_lvl)) // [RQ3]
        else $error("high byte select without both enables");
    chk_low_sel_gate: assert property (!low_sel_r |-> $past(!ram_en_lvl_n && !lower_lvl_n && supply_lvl)) // [RQ4]
        else $error("low byte select without both enables");
    chk_sel_follows: assert property ((!ram_en_lvl_n && !upper_lvl_n && supply_lvl) [*2] |-> !high_sel_r) // [RQ3]
        else $error("high byte select not given");
    chk_int_follow: assert property (alarm_int_r == $past(alarm_flag && alarm_int_enable)) // [RQ5]
        else $error("interrupt does not follow flag and enable");
    chk_fail_reset: assert property (!supply_lvl |=> cpu_reset_oe_r && !access_ok_r) // [RQ9] [RQ6] [RQ10]
        else $error("reset or access not blocked on supply fail");
    chk_fail_sram: assert property (!supply_lvl |=> high_sel_r && low_sel_r) // [RQ16]
        else $error("sram selected during power fail");
    chk_pulse_min: assert property ($fell(cpu_reset_oe_r) |-> $past(rst_len_r) >= CNT_W'(HOLD_CYC - 1)) // [RQ7] [RQ12]
        else $error("reset pulse shorter than hold time");
    chk_wdog_bite: assert property (state_r == ST_RUN && supply_lvl && wdog_hit |=> cpu_reset_oe_r) // [RQ8]
        else $error("watchdog timeout without reset");
    chk_button_bite: assert property (state_r == ST_RUN && supply_lvl && deb_hit |=> cpu_reset_oe_r ##1 cpu_reset_oe_r) // [RQ7]
        else $error("debounced button without reset");
    chk_powerup_hold: assert property (state_r == ST_POWERUP |-> cpu_reset_oe_r && !access_ok_r && !ifc.frame_on) // [RQ11] [RQ12]
        else $error("access or release during powerup hold");
    cov_wdog_pulse: cover property (state_r == ST_RUN && wdog_hit ##1 state_r == ST_PULSE);
    cov_button_pulse: cover property (state_r == ST_RUN && deb_hit ##1 state_r == ST_PULSE);
    cov_powerup_done: cover property (state_r == ST_POWERUP ##1 state_r == ST_RUN);

endmodule // portable_system_supervisor
`default_nettype wire

/* File: tb/host_model.sv */
// host model: serial master of the three-wire link
// assumes the bench resolves the data line from the supervisor output enable alone
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output logic sclk = 1'b0,
    output logic cs = 1'b0,
    output logic h_dat = 1'b0,
    output logic h_oe = 1'b0,
    input wire logic line
);
    // ==========================================
    // bit movement, lsb first
    task automatic put_bits(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            h_dat = v[i];
            h_oe = 1'b1;
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
        h_oe = 1'b0;
        h_dat = ~h_dat; // released line must not keep the last bit
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [7:0] d, input int n, output logic [7:0] got);
        cs = 1'b1;
        #200 put_bits(cmd, n);
        if (n == 8 && cmd[7]) put_bits(d, 8);
        else if (n == 8) for (int i = 0; i < 8; i++) begin
            #100 sclk = 1'b1;
            #100 got[i] = line;
            sclk = 1'b0;
        end
        #200 cs = 1'b0; // clock stands low outside frames
        #200;
    endtask
endmodule // host_model
`default_nettype wire

/* File: tb/tb_portable_system_supervisor.sv */
// bench for the supervisor: power, watchdog, button, sram, alarm, serial
// assumes host_model on the link; counts shortened by parameters
`timescale 1ns/1ps
`default_nettype none
module tb_portable_system_supervisor;
    import supervisor_pkg::*;
    localparam int HOLD = 64;
    localparam int WDOG = 200;
    localparam int DEB = 16;
    logic clk_sys, rstn, supply_ok, sclk, cs, h_dat, h_oe, sd_out, sd_oe, ram_n, up_n, lo_n, hi_s, lo_s;
    logic a_flag, a_en, a_int, kick_n, btn, rst_out, rst_oe, acc, cv, cw, wv;
    logic [1:0] cause;
    logic [6:0] addr;
    logic [7:0] wd, rd, got;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int n_cmd = 0;
    int n_wr = 0;
    int c = 0;
    wire rst_pin_n = ~(rst_oe | btn);
    wire sd_line = sd_oe ? sd_out : h_dat;
    portable_system_supervisor #(.HOLD_CYC(HOLD), .WDOG_CYC(WDOG), .DEBOUNCE_CYC(DEB), .CNT_W(CNT_W_DEF))
    i_portable_system_supervisor (.clk_sys(clk_sys), .rstn(rstn), .supply_ok(supply_ok), .serial_clk(sclk),
        .serial_cs(cs), .serial_data_in(sd_line), .serial_data_out(sd_out), .serial_data_oe(sd_oe),
        .ram_enable_in_n(ram_n), .upper_byte_sel_n(up_n), .lower_byte_sel_n(lo_n),
        .sram_high_byte_select_n(hi_s), .sram_low_byte_select_n(lo_s), .alarm_flag(a_flag),
        .alarm_int_enable(a_en), .alarm_int(a_int), .watchdog_kick_n(kick_n), .cpu_reset_in_n(rst_pin_n),
        .cpu_reset_out(rst_out), .cpu_reset_oe(rst_oe), .reset_cause(cause), .access_ok(acc),
        .cmd_valid(cv), .cmd_write(cw), .cmd_addr(addr), .wr_valid(wv), .wr_data(wd), .rd_data(rd));
    host_model i_host_model (.sclk(sclk), .cs(cs), .h_dat(h_dat), .h_oe(h_oe), .line(sd_line));
    // ==========================================
    // clock, pulse counts, timeout
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        n_cmd <= n_cmd + int'(cv === 1'b1);
        n_wr <= n_wr + int'(wv === 1'b1);
        if (sd_oe === 1'b1 && h_oe === 1'b1) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {sd_oe, h_oe}, 2'h1);
        end
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end
    // ==========================================
    // helpers
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wait_oe(input logic v, input int n);
        c = 0;
        while (rst_oe !== v && c < n) begin
            @(negedge clk_sys);
            c++;
        end
    endtask
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_powerup();
        chk(8'(rst_oe), 8'h01);
        chk(8'(acc), 8'h00);
        wait_oe(1'b0, HOLD + 20);
        chk(8'(c >= HOLD && c <= HOLD + 10), 8'h01);
        chk(8'(acc), 8'h01);
        chk(8'(rst_out), 8'h00);
    endtask
    task automatic t_sram();
        for (int i = 0; i < 8; i++) begin
            {ram_n, up_n, lo_n} = 3'(i);
            repeat (6) @(negedge clk_sys);
            chk(8'(hi_s), 8'(ram_n | up_n));
            chk(8'(lo_s), 8'(ram_n | lo_n));
        end
    endtask
    task automatic t_alarm();
        for (int i = 0; i < 4; i++) begin
            {a_flag, a_en} = 2'(i);
            @(negedge clk_sys);
            chk(8'(a_int), 8'(a_flag & a_en));
        end
    endtask
    task automatic t_write();
        i_host_model.frame(8'hA5, 8'h00, 4, got); // abandoned half command
        c = n_cmd;
        i_host_model.frame(8'hA5, 8'h3C, 8, got);
        repeat (4) @(negedge clk_sys);
        chk(8'(n_cmd - c), 8'h01);
        chk(8'(cw), 8'h01);
        chk(8'(addr), 8'h25);
        chk(wd, 8'h3C);
        chk(8'(n_wr), 8'h01);
    endtask
    task automatic t_read();
        rd = 8'h96;
        i_host_model.frame(8'h12, 8'h00, 8, got);
        chk(got, 8'h96);
        chk(8'(sd_oe), 8'h00);
        chk(8'(cw), 8'h00);
        chk(8'(addr), 8'h12);
    endtask
    task automatic t_fail();
        {supply_ok, ram_n, up_n, lo_n} = 4'h0;
        repeat (8) @(negedge clk_sys);
        chk(8'(rst_oe), 8'h01);
        chk(8'({hi_s, lo_s}), 8'h03);
        c = n_cmd;
        i_host_model.frame(8'h81, 8'h55, 8, got);
        chk(8'(n_cmd - c), 8'h00);
        chk(8'(acc), 8'h00);
        {supply_ok, ram_n, up_n, lo_n} = 4'hF;
        wait_oe(1'b0, HOLD + 20);
        chk(8'(c >= HOLD && c <= HOLD + 10), 8'h01);
        chk(8'(cause), 8'h00);
    endtask
    task automatic t_wdog();
        kick_n = 1'b1;
        wait_oe(1'b1, WDOG + 20);
        chk(8'(c >= WDOG && c <= WDOG + 10), 8'h01);
        chk(8'(cause), 8'h01);
        kick_n = 1'b0;
        wait_oe(1'b0, HOLD + 20);
        chk(8'(c >= HOLD - 2 && c <= HOLD + 2), 8'h01);
    endtask
    task automatic t_button();
        btn = 1'b1;
        repeat (DEB / 2) @(negedge clk_sys);
        btn = 1'b0;
        repeat (DEB) @(negedge clk_sys);
        chk(8'(rst_oe), 8'h00);
        btn = 1'b1;
        wait_oe(1'b1, DEB + 20);
        chk(8'(c >= DEB && c <= DEB + 10), 8'h01);
        chk(8'(cause), 8'h02);
        btn = 1'b0;
        wait_oe(1'b0, HOLD + 20);
        chk(8'(c >= HOLD - 2), 8'h01);
    endtask
    initial begin
        {rstn, supply_ok, ram_n, up_n, lo_n} = 5'h0F;
        {a_flag, a_en, kick_n, btn} = 4'h0;
        rd = 8'h00;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        t_powerup();
        t_sram();
        t_alarm();
        t_write();
        t_read();
        t_fail();
        t_wdog();
        t_button();
        give_verdict();
    end
endmodule // tb_portable_system_supervisor
`default_nettype wire
